// ### verilog/dma_chan_top.sv
`timescale 1ns/10ps
module dma_chan_top #(
   parameter int ADDR_W  = 24, // Transfer address width
   parameter int COUNT_W = 24  // Transfer count width
) (
   input  wire logic               CLK_IN,          // 40 MHz clock
   input  wire logic               RST_IN,          // Sync reset
   input  wire logic [15:0]        AWADDR_IN,       // Write address
   input  wire logic               AWVALID_IN,      // Address valid
   output logic                    AWREADY_OUT,     // Address ready
   input  wire logic [31:0]        WDATA_IN,        // Write data
   input  wire logic [3:0]         WSTRB_IN,        // Byte strobes
   input  wire logic               WVALID_IN,       // Data valid
   output logic                    WREADY_OUT,      // Data ready
   output logic [1:0]              BRESP_OUT,       // Write response
   output logic                    BVALID_OUT,      // Response valid
   input  wire logic               BREADY_IN,       // Response ready
   input  wire logic [15:0]        ARADDR_IN,       // Read address
   input  wire logic               ARVALID_IN,      // Address valid
   output logic                    ARREADY_OUT,     // Address ready
   output logic [31:0]             RDATA_OUT,       // Read data
   output logic [1:0]              RRESP_OUT,       // Read response
   output logic                    RVALID_OUT,      // Read valid
   input  wire logic               RREADY_IN,       // Read ready
   input  wire logic               CAPTURE_REQ_N_IN,   // Capture request
   input  wire logic               CONVERTER_REQ_N_IN, // Converter req
   output logic                    XFER_VALID_OUT,  // One transfer
   output logic [ADDR_W-1:0]       XFER_ADDR_OUT,   // Transfer address
   output logic [1:0]              XFER_SIZE_OUT,   // Transfer size
   output logic                    IRQ_OUT          // Interrupt request
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Merge byte lanes of a write into a word
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Address step in bytes for a size code
   function automatic logic [ADDR_W-1:0] step(input logic [1:0] sz);
      return ADDR_W'(1) << sz;
   endfunction

   // ****************************************************************
   // State
   // ****************************************************************
   logic              aw_got_q, aw_got_d;   // Write address held
   logic [15:0]       aw_q, aw_d;           // Held write address
   logic              w_got_q, w_got_d;     // Write data held
   logic [31:0]       wd_q, wd_d;           // Held write data
   logic [3:0]        ws_q, ws_d;           // Held strobes
   logic              bvalid_q, bvalid_d;   // Write response pending
   logic [1:0]        bresp_q, bresp_d;     // Write response code
   logic              rvalid_q, rvalid_d;   // Read data pending
   logic [31:0]       rdata_q, rdata_d;     // Read data
   logic [1:0]        rresp_q, rresp_d;     // Read response code
   logic              enable_q, enable_d;   // Transfer triggered
   logic              end_q, end_d;         // Transfer end flag
   logic              irq_en_q, irq_en_d;   // Interrupt enable
   logic [1:0]        size_q, size_d;       // Transfer size
   logic              edge_q, edge_d;       // Edge request mode
   logic [3:0]        res_q, res_d;         // Resource select
   logic [1:0]        amode_q, amode_d;     // Address mode
   logic [ADDR_W-1:0] addr_q, addr_d;       // Transfer address
   logic [COUNT_W-1:0] count_q, count_d;    // Remaining transfers
   logic              swreq_q, swreq_d;     // Software request strobe
   logic              xv_q, xv_d;           // Transfer strobe
   logic [ADDR_W-1:0] xa_q, xa_d;           // Transfer address out
   logic [1:0]        xs_q, xs_d;           // Transfer size out
   logic              req_n;                // Selected request line
   logic              req_hit;              // Sensed request
   logic              do_write;             // Write performed now
   logic              do_read;              // Read taken now
   logic              fire;                 // Transfer issued now
   logic [15:0]       ctrl_rd;              // Control read image
   logic [31:0]       wmask;                // Merged write word

   // Control word as software sees it
   assign ctrl_rd = {2'h0, amode_q, res_q, dma_chan_pkg::RSVD7_RESET,
                     edge_q, 1'h0, size_q, irq_en_q, end_q,
                     enable_q};
   assign wmask   = merge(32'h0000_0000, wd_q, ws_q);

   // ****************************************************************
   // Request select and sensing
   // ****************************************************************
   // Route the chosen resource onto the channel's request
   always_comb begin
      unique case (res_q)
         dma_chan_pkg::RES_CAPTURE:   req_n = CAPTURE_REQ_N_IN;
         dma_chan_pkg::RES_CONVERTER: req_n = CONVERTER_REQ_N_IN;
         dma_chan_pkg::RES_SOFTWARE:  req_n = ~swreq_q;
         default:                     req_n = 1'h1; // Reserved: idle
      endcase
   end

   dma_req_sense u_sense (
      .clk_in       (CLK_IN),
      .rst_in       (RST_IN),
      .req_n_in     (req_n),
      .edge_mode_in (edge_q),
      .req_hit_out  (req_hit)
   );

   // Transfer only while triggered and not ended
   assign fire = enable_q & ~end_q & req_hit;

   // ****************************************************************
   // AXI4-Lite slave
   // ****************************************************************
   assign AWREADY_OUT = ~aw_got_q & ~bvalid_q;
   assign WREADY_OUT  = ~w_got_q & ~bvalid_q;
   assign ARREADY_OUT = ~rvalid_q;
   assign do_write    = aw_got_q & w_got_q & ~bvalid_q;
   assign do_read     = ARVALID_IN & ~rvalid_q;

   // Channel handshakes and responses
   always_comb begin
      aw_got_d = aw_got_q;
      aw_d     = aw_q;
      w_got_d  = w_got_q;
      wd_d     = wd_q;
      ws_d     = ws_q;
      bvalid_d = bvalid_q;
      bresp_d  = bresp_q;
      rvalid_d = rvalid_q;
      rdata_d  = rdata_q;
      rresp_d  = rresp_q;
      // Address and data taken in either order
      if (AWVALID_IN && AWREADY_OUT) begin
         aw_got_d = 1'h1;
         aw_d     = AWADDR_IN;
      end
      if (WVALID_IN && WREADY_OUT) begin
         w_got_d = 1'h1;
         wd_d    = WDATA_IN;
         ws_d    = WSTRB_IN;
      end
      // Response after both parts
      if (do_write) begin
         aw_got_d = 1'h0;
         w_got_d  = 1'h0;
         bvalid_d = 1'h1;
         unique case (aw_q & 16'hFFFC)
            dma_chan_pkg::CTRL_OFFSET,
            dma_chan_pkg::ADDR_OFFSET,
            dma_chan_pkg::COUNT_OFFSET,
            dma_chan_pkg::SWREQ_OFFSET: bresp_d = dma_chan_pkg::RESP_OKAY;
            default: bresp_d = dma_chan_pkg::RESP_SLVERR; // Unmapped
         endcase
      end else if (bvalid_q && BREADY_IN) begin
         bvalid_d = 1'h0;
      end
      // Read data one cycle after the address
      if (do_read) begin
         rvalid_d = 1'h1;
         rresp_d  = dma_chan_pkg::RESP_OKAY;
         unique case (ARADDR_IN & 16'hFFFC)
            dma_chan_pkg::CTRL_OFFSET:  rdata_d = {16'h0000, ctrl_rd};
            dma_chan_pkg::ADDR_OFFSET:  rdata_d = 32'(addr_q);
            dma_chan_pkg::COUNT_OFFSET: rdata_d = 32'(count_q);
            dma_chan_pkg::SWREQ_OFFSET: rdata_d = 32'h0000_0000;
            default: begin // Unmapped
               rdata_d = 32'h0000_0000;
               rresp_d = dma_chan_pkg::RESP_SLVERR;
            end
         endcase
      end else if (rvalid_q && RREADY_IN) begin
         rvalid_d = 1'h0;
      end
   end

   // ****************************************************************
   // Channel registers and transfer engine
   // ****************************************************************
   // Software writes first, hardware events override
   always_comb begin
      enable_d = enable_q;
      end_d    = end_q;
      irq_en_d = irq_en_q;
      size_d   = size_q;
      edge_d   = edge_q;
      res_d    = res_q;
      amode_d  = amode_q;
      addr_d   = addr_q;
      count_d  = count_q;
      swreq_d  = 1'h0;
      xv_d     = 1'h0;
      xa_d     = xa_q;
      xs_d     = xs_q;
      if (do_write && (aw_q & 16'hFFFC) == dma_chan_pkg::CTRL_OFFSET) begin
         if (ws_q[0]) begin
            irq_en_d = wd_q[dma_chan_pkg::IRQ_EN_BIT];
            size_d   = wd_q[dma_chan_pkg::SIZE_LSB +: 2];
            edge_d   = wd_q[dma_chan_pkg::EDGE_BIT];
            // Bit five is not stored; software keeps it zero
            if (!wd_q[dma_chan_pkg::END_BIT]) begin
               end_d = 1'h0; // Write zero clears
            end
            if (wd_q[dma_chan_pkg::ENABLE_BIT] && !end_q) begin
               enable_d = 1'h1; // Trigger only when not ended
            end
         end
         if (ws_q[1]) begin
            res_d   = wd_q[dma_chan_pkg::RES_LSB +: 4];
            amode_d = wd_q[dma_chan_pkg::AMODE_LSB +: 2];
         end
      end
      if (do_write && (aw_q & 16'hFFFC) == dma_chan_pkg::ADDR_OFFSET) begin
         addr_d = ADDR_W'(merge(32'(addr_q), wd_q, ws_q));
      end
      if (do_write && (aw_q & 16'hFFFC) == dma_chan_pkg::COUNT_OFFSET) begin
         count_d = COUNT_W'(merge(32'(count_q), wd_q, ws_q));
      end
      if (do_write && (aw_q & 16'hFFFC) == dma_chan_pkg::SWREQ_OFFSET) begin
         swreq_d = wmask[dma_chan_pkg::SWREQ_BIT];
      end
      // Triggered with nothing left: end at once
      if (enable_q && !end_q && count_q == '0) begin
         enable_d = 1'h0;
         end_d    = 1'h1;
      end
      // One transfer per sensed request
      if (fire && count_q != '0) begin
         xv_d    = 1'h1;
         xa_d    = addr_q;
         xs_d    = size_q;
         count_d = count_q - COUNT_W'(1);
         unique case (amode_q)
            dma_chan_pkg::AMODE_INC: addr_d = addr_q + step(size_q);
            dma_chan_pkg::AMODE_DEC: addr_d = addr_q - step(size_q);
            default:                 addr_d = addr_q; // Fixed, reserved
         endcase
         if (count_q == COUNT_W'(1)) begin
            enable_d = 1'h0;
            end_d    = 1'h1; // Set beats a same-cycle clear
         end
      end
   end

   // Register all state
   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         aw_got_q <= 1'h0;
         aw_q     <= 16'h0000;
         w_got_q  <= 1'h0;
         wd_q     <= 32'h0000_0000;
         ws_q     <= 4'h0;
         bvalid_q <= 1'h0;
         bresp_q  <= dma_chan_pkg::RESP_OKAY;
         rvalid_q <= 1'h0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= dma_chan_pkg::RESP_OKAY;
         enable_q <= dma_chan_pkg::CTRL_RESET[dma_chan_pkg::ENABLE_BIT];
         end_q    <= dma_chan_pkg::CTRL_RESET[dma_chan_pkg::END_BIT];
         irq_en_q <= dma_chan_pkg::CTRL_RESET[dma_chan_pkg::IRQ_EN_BIT];
         size_q   <= dma_chan_pkg::CTRL_RESET[dma_chan_pkg::SIZE_LSB +: 2];
         edge_q   <= dma_chan_pkg::CTRL_RESET[dma_chan_pkg::EDGE_BIT];
         res_q    <= dma_chan_pkg::CTRL_RESET[dma_chan_pkg::RES_LSB +: 4];
         amode_q  <= dma_chan_pkg::CTRL_RESET[dma_chan_pkg::AMODE_LSB +: 2];
         addr_q   <= ADDR_W'(dma_chan_pkg::ADDR_RESET);
         count_q  <= COUNT_W'(dma_chan_pkg::COUNT_RESET);
         swreq_q  <= 1'h0;
         xv_q     <= 1'h0;
         xa_q     <= '0;
         xs_q     <= dma_chan_pkg::SIZE_8;
      end else begin
         aw_got_q <= aw_got_d;
         aw_q     <= aw_d;
         w_got_q  <= w_got_d;
         wd_q     <= wd_d;
         ws_q     <= ws_d;
         bvalid_q <= bvalid_d;
         bresp_q  <= bresp_d;
         rvalid_q <= rvalid_d;
         rdata_q  <= rdata_d;
         rresp_q  <= rresp_d;
         enable_q <= enable_d;
         end_q    <= end_d;
         irq_en_q <= irq_en_d;
         size_q   <= size_d;
         edge_q   <= edge_d;
         res_q    <= res_d;
         amode_q  <= amode_d;
         addr_q   <= addr_d;
         count_q  <= count_d;
         swreq_q  <= swreq_d;
         xv_q     <= xv_d;
         xa_q     <= xa_d;
         xs_q     <= xs_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   assign BVALID_OUT     = bvalid_q;
   assign BRESP_OUT      = bresp_q;
   assign RVALID_OUT     = rvalid_q;
   assign RDATA_OUT      = rdata_q;
   assign RRESP_OUT      = rresp_q;
   assign XFER_VALID_OUT = xv_q;
   assign XFER_ADDR_OUT  = xa_q;
   assign XFER_SIZE_OUT  = xs_q;
   assign IRQ_OUT        = end_q & irq_en_q;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   sequence last_s;
      fire && count_q == COUNT_W'(1);
   endsequence

   irq_gate_a: assert property (!irq_en_q |-> !IRQ_OUT)
      else $error("Interrupt while disabled");
   done_irq_a: assert property (
      last_s ##0 irq_en_q ##0 !do_write |=> IRQ_OUT && end_q)
      else $error("No interrupt at count zero");
   refuse_a: assert property (end_q |=> !XFER_VALID_OUT)
      else $error("Transfer after completion");
   size_out_a: assert property (
      fire && count_q != '0 |=> XFER_VALID_OUT
         && XFER_SIZE_OUT == $past(size_q))
      else $error("Transfer size wrong");
   inc_step_a: assert property (
      fire && count_q != '0 && amode_q == dma_chan_pkg::AMODE_INC
         && !do_write |=> addr_q == $past(addr_q) + step($past(size_q)))
      else $error("Increment step wrong");
   rsvd7_a: assert property (
      do_read && (ARADDR_IN & 16'hFFFC) == dma_chan_pkg::CTRL_OFFSET
         |=> !RDATA_OUT[dma_chan_pkg::RSVD7_BIT])
      else $error("Reserved bit seven set");
   capture_sel_a: assert property (
      res_q == dma_chan_pkg::RES_CAPTURE |-> req_n == CAPTURE_REQ_N_IN)
      else $error("Capture request not routed");
   bresp_a: assert property (do_write |=> BVALID_OUT)
      else $error("Write response missing");

endmodule // dma_chan_top

// ### verilog/dma_chan_pkg.sv
// ****************************************************************
// Shared constants of the channel
// ****************************************************************
package dma_chan_pkg;

   // ****************************************************************
   // Register byte addresses
   // ****************************************************************
   localparam logic [15:0] CTRL_OFFSET  = 16'h3C1C; // Channel control
   localparam logic [15:0] ADDR_OFFSET  = 16'h3C20; // Transfer address
   localparam logic [15:0] COUNT_OFFSET = 16'h3C24; // Remaining count
   localparam logic [15:0] SWREQ_OFFSET = 16'h3C28; // Software request

   // ****************************************************************
   // Control field positions
   // ****************************************************************
   localparam int ENABLE_BIT  = 0;  // Transfer triggered
   localparam int END_BIT     = 1;  // Transfer end flag
   localparam int IRQ_EN_BIT  = 2;  // Interrupt request enable
   localparam int SIZE_LSB    = 3;  // Transfer size, two bits
   localparam int RSVD5_BIT   = 5;  // Reserved, write zero
   localparam int EDGE_BIT    = 6;  // Request input mode
   localparam int RSVD7_BIT   = 7;  // Reserved, reads zero
   localparam int RES_LSB     = 8;  // Resource select, four bits
   localparam int AMODE_LSB   = 12; // Address mode, two bits
   localparam int SWREQ_BIT   = 0;  // Software request strobe

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] CTRL_RESET  = 16'h0000; // Control fields
   localparam logic [31:0] ADDR_RESET  = 32'h0000_0000; // Address
   localparam logic [31:0] COUNT_RESET = 32'h0000_0000; // Count
   localparam logic        RSVD7_RESET = 1'h0;  // Reserved bit seven

   // ****************************************************************
   // Encodings
   // ****************************************************************
   localparam logic [1:0] SIZE_8   = 2'h0; // 8-bit transfers
   localparam logic [1:0] SIZE_16  = 2'h1; // 16-bit transfers
   localparam logic [1:0] SIZE_32  = 2'h2; // 32-bit transfers
   localparam logic [1:0] SIZE_64  = 2'h3; // 64-bit transfers
   localparam logic [3:0] RES_CAPTURE   = 4'h0; // Captured video data
   localparam logic [3:0] RES_CONVERTER = 4'h1; // Colour converter path
   localparam logic [3:0] RES_SOFTWARE  = 4'hF; // Software request
   localparam logic [1:0] AMODE_FIXED = 2'h0; // Address held
   localparam logic [1:0] AMODE_INC   = 2'h1; // Address increments
   localparam logic [1:0] AMODE_DEC   = 2'h2; // Address decrements
   localparam logic [1:0] RESP_OKAY   = 2'h0; // AXI OKAY
   localparam logic [1:0] RESP_SLVERR = 2'h2; // AXI SLVERR

endpackage

// ### verilog/dma_req_sense.sv
`timescale 1ns/10ps
// ****************************************************************
// Request line sensing: active-low level or falling edge
// ****************************************************************
module dma_req_sense (
   input  wire logic clk_in,       // System clock
   input  wire logic rst_in,       // Synchronous reset
   input  wire logic req_n_in,     // Selected request, active low
   input  wire logic edge_mode_in, // High selects falling edge
   output logic      req_hit_out   // Service requested this cycle
);

   logic prev_q; // Previous sample of the request line
   logic prev_d; // Next previous sample

   // Next sample value
   always_comb begin
      prev_d = req_n_in;
   end

   // Sample register, idle high after reset
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         prev_q <= 1'h1;
      end else begin
         prev_q <= prev_d;
      end
   end

   // Level: low requests; edge: high then low requests
   always_comb begin
      if (edge_mode_in) begin
         req_hit_out = prev_q & ~req_n_in;
      end else begin
         req_hit_out = ~req_n_in;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   sequence fall_s;
      $past(req_n_in) ##0 !req_n_in;
   endsequence

   edge_hit_a: assert property (
      (edge_mode_in && $past(edge_mode_in)) ##0 fall_s |-> req_hit_out)
      else $error("Falling edge missed");
   edge_hold_a: assert property (
      (edge_mode_in && $past(!req_n_in)) |-> !req_hit_out)
      else $error("Held low line seen as edge");
   level_hit_a: assert property (
      !edge_mode_in |-> req_hit_out == !req_n_in)
      else $error("Level request wrong");

endmodule // dma_req_sense

// ### sim/dma_req_model.sv
`timescale 1ns/10ps
// ****************************************************************
// Requesting resource: active-low line held low for a span
// ****************************************************************
module dma_req_model (
   input  wire logic       clk_in,    // System clock
   input  wire logic       rst_in,    // Synchronous reset
   input  wire logic       fire_in,   // Start a request burst
   input  wire logic [3:0] len_in,    // Cycles held low
   output logic            req_n_out  // Request, active low
);
   logic [3:0] left_q; // Cycles still low
   // Count the burst down; the line idles high between bursts
   always_ff @(posedge clk_in) begin
      if (rst_in) left_q <= 4'h0;
      else if (fire_in) left_q <= len_in;
      else if (left_q != 4'h0) left_q <= left_q - 4'h1;
   end
   assign req_n_out = (left_q == 4'h0);
endmodule // dma_req_model

// ### sim/dma_chan_top_tb_top.sv
`timescale 1ns/10ps
// ****************************************************************
// Channel bench: bus master, two requesters, transfer monitor
// ****************************************************************
module dma_chan_top_tb_top;
   logic clk = 0, rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [15:0] awa = 0, ara = 0; // Bus addresses
   logic [31:0] wd = 0, rd;       // Bus data
   logic [3:0]  la = 0, lb = 0;   // Burst lengths
   logic        fa = 0, fb = 0, rqa, rqb, awr, wr, bv, arr, rv, xv, irq;
   logic [1:0]  bresp, rresp, xso, xs, lastb; // Responses, sizes
   logic [23:0] xao, xa [8];           // Transfer addresses
   int bad_count = 0, checked = 0, xn = 0, seed = 32'h5f5e;
   always #12.5 clk = ~clk; // 40 MHz
   dma_chan_top dma_chan_top_i (.CLK_IN(clk), .RST_IN(rst),
      .AWADDR_IN(awa), .AWVALID_IN(awv), .AWREADY_OUT(awr),
      .WDATA_IN(wd), .WSTRB_IN(4'hF), .WVALID_IN(wv), .WREADY_OUT(wr),
      .BRESP_OUT(bresp), .BVALID_OUT(bv), .BREADY_IN(br),
      .ARADDR_IN(ara), .ARVALID_IN(arv), .ARREADY_OUT(arr),
      .RDATA_OUT(rd), .RRESP_OUT(rresp), .RVALID_OUT(rv), .RREADY_IN(rr),
      .CAPTURE_REQ_N_IN(rqa), .CONVERTER_REQ_N_IN(rqb),
      .XFER_VALID_OUT(xv), .XFER_ADDR_OUT(xao), .XFER_SIZE_OUT(xso),
      .IRQ_OUT(irq));
   dma_req_model dma_req_model_i (.clk_in(clk), .rst_in(rst),
      .fire_in(fa), .len_in(la), .req_n_out(rqa));
   dma_req_model dma_req_model_b_i (.clk_in(clk), .rst_in(rst),
      .fire_in(fb), .len_in(lb), .req_n_out(rqb));
   // Record every transfer pulse
   always @(posedge clk) if (xv === 1'b1) begin
      xa[xn[2:0]] <= xao;
      xs <= xso;
      xn <= xn + 1;
   end
   // Verdict and end of run
   task results;
      if (bad_count == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // One comparison
   task chk(input logic ok, input string m);
      checked++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask
   // Address step in bytes for a size code
   function logic [23:0] step(input logic [1:0] s);
      return 24'h1 << s;
   endfunction
   // Next transfer address for an address mode
   function logic [23:0] nxt(input logic [23:0] v, input logic [1:0] m,
                             input logic [1:0] s);
      if (m == 2'h1) return v + step(s);
      if (m == 2'h2) return v - step(s);
      return v;
   endfunction
   // Bus write; each channel released at the edge it is taken
   task axw(input logic [15:0] a, input logic [31:0] d);
      logic done;
      awa <= a; wd <= d; awv <= 1; wv <= 1; br <= 1; done = 0;
      while (!done) begin
         @(posedge clk);
         if (awv && awr) awv <= 0;
         if (wv && wr) wv <= 0;
         if (br && bv) begin
            lastb = bresp;
            br <= 0;
            done = 1;
         end
      end
      @(posedge clk); // Keep bready low for one edge
   endtask
   // Bus read; data taken at the edge rvalid is sampled
   task axr(input logic [15:0] a, output logic [31:0] r,
            output logic [1:0] p);
      logic done;
      ara <= a; arv <= 1; rr <= 1; done = 0;
      while (!done) begin
         @(posedge clk);
         if (arv && arr) arv <= 0;
         if (rr && rv) begin
            r = rd;
            p = rresp;
            rr <= 0;
            done = 1;
         end
      end
      @(posedge clk); // Keep rready low for one edge
   endtask
   // Burst on one requester, then let the channel settle
   task fire(input logic conv, input logic [3:0] n);
      if (conv) begin fb <= 1; lb <= n; end
      else begin fa <= 1; la <= n; end
      @(posedge clk);
      fa <= 0; fb <= 0;
      repeat (8) @(posedge clk);
   endtask
   // Watchdog
   initial begin
      #1000000;
      bad_count++;
      results;
   end
   // Main sequence: sizes, modes, resources, end flag
   initial begin
      logic [31:0] r, cw;
      logic [1:0]  p, sz, am;
      logic [3:0]  res;
      logic        ie, edg, sw;
      logic [23:0] a;
      int          n0, ex;
      for (int i = 0; i < 7; i++) begin
         rst <= 1;
         repeat (2) @(posedge clk);
         rst <= 0;
         @(posedge clk);
         sz = i[1:0]; edg = (i > 3); sw = (i == 6);
         res = sw ? 4'hF : {3'h0, 1'($random(seed))};
         ie = 1'($random(seed)); a = 24'($random(seed)) & 24'hFFFFF0;
         ex = (edg || sw) ? 1 : 2;
         am = 2'(i % 3);
         axr(dma_chan_pkg::CTRL_OFFSET, r, p);
         chk(r === 32'h0, "ctrl reset");
         axw(dma_chan_pkg::ADDR_OFFSET, {8'h0, a});
         axw(dma_chan_pkg::COUNT_OFFSET, 32'h2);
         n0 = xn;
         cw = {18'h0, am, res, 1'b1, edg, 1'b0, sz, ie, 2'h1};
         axw(dma_chan_pkg::CTRL_OFFSET, cw);
         chk(lastb === dma_chan_pkg::RESP_OKAY, "write response");
         if (sw) begin
            axw(dma_chan_pkg::SWREQ_OFFSET, 32'h1);
            repeat (8) @(posedge clk);
         end else begin
            fire(res == 4'h0, 4'h4);
            chk(xn === n0, "unselected fired");
            fire(res == 4'h1, 4'h4);
         end
         chk(xn === n0 + ex, "transfer count");
         chk(xa[n0[2:0]] === a, "first address");
         if (ex == 2) begin
            chk(xa[n0[2:0] + 3'h1] === nxt(a, am, sz), "step");
         end
         chk(xs === sz, "size");
         chk(irq === (ie && ex == 2), "irq");
         axr(dma_chan_pkg::CTRL_OFFSET, r, p);
         chk(r === {18'h0, am, res, 1'b0, edg, 1'b0, sz, ie, ex == 2,
             ex != 2}, "ctrl fields");
         // Ended channel refuses a trigger until the flag is cleared
         if (ex == 2) begin
            axw(dma_chan_pkg::COUNT_OFFSET, 32'h2);
            axw(dma_chan_pkg::CTRL_OFFSET, cw | 32'h3);
            n0 = xn;
            fire(res == 4'h1, 4'h4);
            chk(xn === n0, "ended refuse");
            axw(dma_chan_pkg::CTRL_OFFSET, cw & ~32'h3);
            axr(dma_chan_pkg::CTRL_OFFSET, r, p);
            chk(r[1:0] === 2'h0 && irq === 1'b0, "end clear");
         end
      end
      // Reserved resource code gives no request
      axw(dma_chan_pkg::CTRL_OFFSET, 32'h0000_0201);
      n0 = xn;
      fire(1'b0, 4'h4);
      fire(1'b1, 4'h4);
      chk(xn === n0, "reserved resource");
      axw(16'h3000, 32'h0000_0001);
      chk(lastb === dma_chan_pkg::RESP_SLVERR, "unmapped write");
      axr(16'h3000, r, p);
      chk(p === dma_chan_pkg::RESP_SLVERR && r === 32'h0, "unmapped");
      results;
   end
endmodule // dma_chan_top_tb_top
